// file: hmawc_defines.svh
// register offsets, field positions, reset values and timing counts for the halt/autowake controller
// assumes a 32-bit apb slave where each register takes one aligned word
`ifndef HMAWC_DEFINES_SVH
`define HMAWC_DEFINES_SVH

// ---------------------------------------------
// register byte addresses
// ---------------------------------------------
`define HMAWC_OFS_CSR 12'h000
`define HMAWC_OFS_PRESC 12'h004
`define HMAWC_OFS_HALTCFG 12'h008
`define HMAWC_OFS_STATUS 12'h00C

// ---------------------------------------------
// field positions and reset values
// ---------------------------------------------
`define HMAWC_CSR_EN_BIT 0
`define HMAWC_CSR_MEAS_BIT 1
`define HMAWC_CSR_FLAG_BIT 2
`define HMAWC_CSR_RESET 8'h00
`define HMAWC_PRESC_RESET 8'hFF
`define HMAWC_HALT_OPCODE 8'h8E

// ---------------------------------------------
// timing
// ---------------------------------------------
`define HMAWC_STAB_CYCLES 9'h100
`define HMAWC_FIXED_DIV 8'h40
`define HMAWC_RST_PULSE_NS 42000

`endif

// file: hmawc_pkg.sv
// types shared by the halt/autowake controller
// assumes nothing beyond a systemverilog compiler
package hmawc_pkg;
   // gray coded along halt -> stabilise -> run; run -> halt flips both bits
   typedef enum logic [1:0] {
      HMAWC_RUN = 2'b00,
      HMAWC_ACTIVE_HALT = 2'b01,
      HMAWC_HALT = 2'b11,
      HMAWC_STAB = 2'b10
   } hmawc_state_type;
endpackage : hmawc_pkg

// file: hmawc_top.sv
// halt, active-halt and auto-wakeup-from-halt controller with apb registers
// assumes the cpu presents each fetched opcode with a strobe, and the rc and wake inputs are asynchronous
//
// What this block does
// - halt picks active-halt when timebase irq or overflow irq with clock 0/1 enabled
// - active-halt wakes only on lite timer, second timer interrupt or reset
// - reset out of active-halt waits 256 cycles before reset vector fetch
// - interrupt out of active-halt resumes at once, no stabilisation delay
// - entering active-halt clears the interrupt mask bit
// - active-halt keeps only main oscillator and selected timer clocked
// - active-halt with watchdog-halt option cleared gives no watchdog reset
// - plain halt when active-halt disabled; exit by reset or halt-capable interrupt
// - plain halt exit restarts oscillator and waits 256 cycles
// - entering plain halt forces interrupt mask to 0
// - plain halt stops main oscillator and internal peripherals
// - halt with watchdog on resets or not per watchdog-halt option
// - opcode 0x8E is decoded as the halt instruction
// - halt with autowake enable starts the rc oscillator as wake time base
// - elapsed autowake delay sets flag, raises interrupt, restarts oscillator with 256-cycle wait
// - read of autowake control/status clears flag and pending interrupt
// - measure bit in run routes rc clock to lite timer capture
// - autowake halt otherwise behaves as plain halt
// - bit 2 is hardware-set flag, write-ignored; bits 7:3 reserved
// - bit 1 enables rc oscillator and capture connection
// - bit 0 enables autowake from halt, software set and clear
// - prescaler 1..255 divides, resets to FFh, write of 00h ignored
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "hmawc_defines.svh"

module hmawc_top (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // cpu side
   input wire logic OPCODE_VALID,
   input wire logic [7:0] OPCODE,
   input wire logic CPU_RESET_REQ,
   input wire logic IRQ_PENDING,
   // timer and watchdog configuration
   input wire logic TIMEBASE_IRQ_ENABLE,
   input wire logic OVERFLOW_IRQ_ENABLE,
   input wire logic SECOND_TIMER_CLOCK_SEL_HI,
   input wire logic SECOND_TIMER_CLOCK_SEL_LO,
   input wire logic WATCHDOG_ENABLED,
   input wire logic WATCHDOG_HALT_OPTION,
   // asynchronous wake sources
   input wire logic LITE_TIMER_IRQ,
   input wire logic SECOND_TIMER_IRQ,
   input wire logic HALT_EXIT_IRQ,
   input wire logic AUTOWAKE_RC_CLK,
   // outputs
   output logic MAIN_OSC_ON,
   output logic TIMER_CLK_EN,
   output logic PERIPH_CLK_EN,
   output logic CPU_STALL,
   output logic CLEAR_IRQ_MASK,
   output logic FETCH_RESET_VECTOR,
   output logic SERVICE_IRQ,
   output logic WATCHDOG_RESET,
   output logic AUTOWAKE_IRQ,
   output logic AUTOWAKE_RC_EN,
   output logic LITE_TIMER_CAPTURE
);

   // ---------------------------------------------
   // input synchronisers: a change counts when stages two and three agree
   // ---------------------------------------------
   // bit order: lite timer irq, second timer irq, halt-exit irq, rc clock
   // the rc clock is treated as a level, so its edges are found after the filter
   logic [3:0] async_in;
   logic [3:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
   logic [3:0] filt_q, filt_d;
   assign async_in = {AUTOWAKE_RC_CLK, HALT_EXIT_IRQ, SECOND_TIMER_IRQ, LITE_TIMER_IRQ};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
         always_comb begin
            s1_d[gi] = async_in[gi];
            s2_d[gi] = s1_q[gi];
            s3_d[gi] = s2_q[gi];
            filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
         end
      end
   endgenerate

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s1_q <= 4'h0;
         s2_q <= 4'h0;
         s3_q <= 4'h0;
         filt_q <= 4'h0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         filt_q <= filt_d;
      end
   end

   logic lt_irq, at_irq, hx_irq, rc_lvl;
   assign lt_irq = filt_q[0];
   assign at_irq = filt_q[1];
   assign hx_irq = filt_q[2];
   assign rc_lvl = filt_q[3];

   // ---------------------------------------------
   // apb register file
   // ---------------------------------------------
   logic en_q, en_d, meas_q, meas_d, flag_q, flag_d;
   logic [7:0] presc_q, presc_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic acc, wr, rd, mapped, rd_csr, aw_event;
   hmawc_pkg::hmawc_state_type st_q, st_d;

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `HMAWC_OFS_CSR) || (a == `HMAWC_OFS_PRESC) ||
                  (a == `HMAWC_OFS_HALTCFG) || (a == `HMAWC_OFS_STATUS);
   endfunction : is_mapped

   // one wait state: pready rises in the cycle after the access is taken
   assign acc = PSEL && PENABLE && !pready_q;
   assign wr = acc && PWRITE;
   assign rd = acc && !PWRITE;
   assign mapped = is_mapped(PADDR);
   assign rd_csr = rd && (PADDR == `HMAWC_OFS_CSR);

   always_comb begin
      en_d = en_q;
      meas_d = meas_q;
      presc_d = presc_q;
      prdata_d = prdata_q;
      pready_d = acc;
      pslverr_d = acc && !mapped;
      if (wr && PADDR == `HMAWC_OFS_CSR) begin
         en_d = PWDATA[`HMAWC_CSR_EN_BIT];
         meas_d = PWDATA[`HMAWC_CSR_MEAS_BIT];
      end
      if (wr && PADDR == `HMAWC_OFS_PRESC && PWDATA[7:0] != 8'h00) begin
         presc_d = PWDATA[7:0];
      end
      // flag bit ignores writes; a new event wins over the read clear
      flag_d = aw_event ? 1'b1 : (rd_csr ? 1'b0 : flag_q);
      if (rd) begin
         case (PADDR)
            `HMAWC_OFS_CSR: prdata_d = {29'h0, flag_q, meas_q, en_q};
            `HMAWC_OFS_PRESC: prdata_d = {24'h0, presc_q};
            `HMAWC_OFS_HALTCFG: prdata_d = {28'h0, SECOND_TIMER_CLOCK_SEL_HI, SECOND_TIMER_CLOCK_SEL_LO,
                                             OVERFLOW_IRQ_ENABLE, TIMEBASE_IRQ_ENABLE};
            `HMAWC_OFS_STATUS: prdata_d = {30'h0, st_q};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         en_q <= 1'b0;
         meas_q <= 1'b0;
         flag_q <= 1'b0;
         presc_q <= `HMAWC_PRESC_RESET;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         en_q <= en_d;
         meas_q <= meas_d;
         flag_q <= flag_d;
         presc_q <= presc_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ---------------------------------------------
   // halt sequencer
   // ---------------------------------------------
   logic halt_op, ah_enable, wake_ah, wake_halt;
   logic [8:0] stab_q, stab_d;
   logic from_reset_q, from_reset_d, aw_run_q, aw_run_d;
   logic [7:0] fdiv_q, fdiv_d, pcnt_q, pcnt_d;
   logic rc_prev_q, rc_prev_d, rc_rise;
   logic clr_mask_d, svc_d, fetch_d, wdg_d;

   assign halt_op = OPCODE_VALID && (OPCODE == `HMAWC_HALT_OPCODE);
   assign ah_enable = TIMEBASE_IRQ_ENABLE ||
                      (OVERFLOW_IRQ_ENABLE && !SECOND_TIMER_CLOCK_SEL_HI && SECOND_TIMER_CLOCK_SEL_LO);
   assign wake_ah = lt_irq || at_irq;
   assign wake_halt = hx_irq || IRQ_PENDING;
   assign rc_rise = rc_lvl && !rc_prev_q;
   // delay: rc edges through the fixed divider, then the prescaler
   assign aw_event = aw_run_q && rc_rise && (fdiv_q == `HMAWC_FIXED_DIV - 8'h01) &&
                     (pcnt_q == presc_q - 8'h01);

   always_comb begin
      st_d = st_q;
      stab_d = stab_q;
      from_reset_d = from_reset_q;
      aw_run_d = aw_run_q;
      fdiv_d = fdiv_q;
      pcnt_d = pcnt_q;
      rc_prev_d = rc_lvl;
      clr_mask_d = 1'b0;
      svc_d = 1'b0;
      fetch_d = 1'b0;
      wdg_d = 1'b0;
      case (st_q)
         hmawc_pkg::HMAWC_RUN: begin
            if (halt_op) begin
               clr_mask_d = 1'b1;
               if (WATCHDOG_ENABLED && WATCHDOG_HALT_OPTION) begin
                  wdg_d = 1'b1;
               end else if (ah_enable) begin
                  st_d = hmawc_pkg::HMAWC_ACTIVE_HALT;
               end else begin
                  st_d = hmawc_pkg::HMAWC_HALT;
                  aw_run_d = en_q;
                  fdiv_d = 8'h00;
                  pcnt_d = 8'h00;
               end
            end
         end
         hmawc_pkg::HMAWC_ACTIVE_HALT: begin
            if (CPU_RESET_REQ) begin
               st_d = hmawc_pkg::HMAWC_STAB;
               from_reset_d = 1'b1;
               stab_d = 9'h000;
            end else if (wake_ah) begin
               st_d = hmawc_pkg::HMAWC_RUN;
               svc_d = 1'b1;
            end
         end
         hmawc_pkg::HMAWC_HALT: begin
            if (aw_run_q && rc_rise) begin
               fdiv_d = (fdiv_q == `HMAWC_FIXED_DIV - 8'h01) ? 8'h00 : fdiv_q + 8'h01;
               if (fdiv_q == `HMAWC_FIXED_DIV - 8'h01) begin
                  pcnt_d = pcnt_q + 8'h01;
               end
            end
            if (CPU_RESET_REQ || wake_halt || aw_event) begin
               st_d = hmawc_pkg::HMAWC_STAB;
               from_reset_d = CPU_RESET_REQ;
               stab_d = 9'h000;
               aw_run_d = 1'b0;
            end
         end
         hmawc_pkg::HMAWC_STAB: begin
            stab_d = stab_q + 9'h001;
            if (stab_q == `HMAWC_STAB_CYCLES - 9'h001) begin
               st_d = hmawc_pkg::HMAWC_RUN;
               fetch_d = from_reset_q;
               svc_d = !from_reset_q;
               from_reset_d = 1'b0;
            end
         end
         default: st_d = hmawc_pkg::HMAWC_RUN;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q <= hmawc_pkg::HMAWC_RUN;
         stab_q <= 9'h000;
         from_reset_q <= 1'b0;
         aw_run_q <= 1'b0;
         fdiv_q <= 8'h00;
         pcnt_q <= 8'h00;
         rc_prev_q <= 1'b0;
         CLEAR_IRQ_MASK <= 1'b0;
         SERVICE_IRQ <= 1'b0;
         FETCH_RESET_VECTOR <= 1'b0;
         WATCHDOG_RESET <= 1'b0;
      end else begin
         st_q <= st_d;
         stab_q <= stab_d;
         from_reset_q <= from_reset_d;
         aw_run_q <= aw_run_d;
         fdiv_q <= fdiv_d;
         pcnt_q <= pcnt_d;
         rc_prev_q <= rc_prev_d;
         CLEAR_IRQ_MASK <= clr_mask_d;
         SERVICE_IRQ <= svc_d;
         FETCH_RESET_VECTOR <= fetch_d;
         WATCHDOG_RESET <= wdg_d;
      end
   end

   // ---------------------------------------------
   // clock gating and output registers
   // ---------------------------------------------
   logic osc_d, tmr_d, per_d, stall_d, rcen_d, cap_d;
   always_comb begin
      osc_d = (st_d != hmawc_pkg::HMAWC_HALT);
      tmr_d = (st_d != hmawc_pkg::HMAWC_HALT);
      per_d = (st_d == hmawc_pkg::HMAWC_RUN);
      stall_d = (st_d != hmawc_pkg::HMAWC_RUN);
      rcen_d = aw_run_d || (meas_d && st_d == hmawc_pkg::HMAWC_RUN);
      cap_d = meas_q && st_q == hmawc_pkg::HMAWC_RUN && rc_lvl;
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         MAIN_OSC_ON <= 1'b1;
         TIMER_CLK_EN <= 1'b1;
         PERIPH_CLK_EN <= 1'b1;
         CPU_STALL <= 1'b0;
         AUTOWAKE_RC_EN <= 1'b0;
         LITE_TIMER_CAPTURE <= 1'b0;
      end else begin
         MAIN_OSC_ON <= osc_d;
         TIMER_CLK_EN <= tmr_d;
         PERIPH_CLK_EN <= per_d;
         CPU_STALL <= stall_d;
         AUTOWAKE_RC_EN <= rcen_d;
         LITE_TIMER_CAPTURE <= cap_d;
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign AUTOWAKE_IRQ = flag_q;

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   sequence s_stab_start;
      st_q == hmawc_pkg::HMAWC_STAB && stab_q == 9'h000;
   endsequence

   chk_stab_length: assert property (@(posedge CLK) disable iff (!RST_N)
      s_stab_start |-> ##255 (st_q == hmawc_pkg::HMAWC_STAB) ##1 (st_q == hmawc_pkg::HMAWC_RUN))
      else $error("stabilisation not 256 cycles");
   chk_ah_reset_wait: assert property (@(posedge CLK) disable iff (!RST_N)
      (st_q == hmawc_pkg::HMAWC_ACTIVE_HALT && CPU_RESET_REQ) |-> ##257 FETCH_RESET_VECTOR)
      else $error("reset vector not fetched after delay");
   chk_ah_irq_now: assert property (@(posedge CLK) disable iff (!RST_N)
      (st_q == hmawc_pkg::HMAWC_ACTIVE_HALT && !CPU_RESET_REQ && wake_ah) |=> SERVICE_IRQ && !CPU_STALL)
      else $error("active-halt irq wake not immediate");
   chk_mask_clear: assert property (@(posedge CLK) disable iff (!RST_N)
      $rose(st_q != hmawc_pkg::HMAWC_RUN && st_q != hmawc_pkg::HMAWC_STAB) |-> CLEAR_IRQ_MASK)
      else $error("halt entered without mask clear");
   chk_ah_select: assert property (@(posedge CLK) disable iff (!RST_N)
      (st_q == hmawc_pkg::HMAWC_RUN && halt_op && !(WATCHDOG_ENABLED && WATCHDOG_HALT_OPTION))
      |=> st_q == (ah_enable ? hmawc_pkg::HMAWC_ACTIVE_HALT : hmawc_pkg::HMAWC_HALT))
      else $error("wrong halt mode chosen");
   chk_osc_off: assert property (@(posedge CLK) disable iff (!RST_N)
      st_q == hmawc_pkg::HMAWC_HALT |-> !MAIN_OSC_ON)
      else $error("oscillator running in halt");
   chk_presc_zero: assert property (@(posedge CLK) disable iff (!RST_N)
      (wr && PADDR == `HMAWC_OFS_PRESC && PWDATA[7:0] == 8'h00) |=> $stable(presc_q))
      else $error("prescaler took zero");
   chk_flag_read: assert property (@(posedge CLK) disable iff (!RST_N)
      (rd_csr && !aw_event) |=> !AUTOWAKE_IRQ)
      else $error("flag not cleared by read");
   chk_wdg_halt: assert property (@(posedge CLK) disable iff (!RST_N)
      (st_q == hmawc_pkg::HMAWC_RUN && halt_op && WATCHDOG_ENABLED && WATCHDOG_HALT_OPTION) |=> WATCHDOG_RESET)
      else $error("watchdog reset missing");

endmodule : hmawc_top

// file: hmawc_partner.sv
// partner model: the auto-wakeup rc oscillator and the external reset source of the controller
// assumes the bench supplies the main clock; the rc oscillator runs only while the controller enables it
`timescale 1ns/10ps

module hmawc_partner (
   // main clock
   input wire logic clk,
   // rc oscillator
   input wire logic rc_en,
   output logic rc_clk,
   // reset source
   output logic reset_req
);
   // ---------------------------------------------
   // rc oscillator
   // ---------------------------------------------
   initial begin
      rc_clk = 1'b0;
      reset_req = 1'b0;
   end

   // 97 ns half period keeps rc edges unrelated to clk; stands still while disabled
   always begin
      wait (rc_en === 1'b1);
      #97 rc_clk = ~rc_clk;
   end

   // ---------------------------------------------
   // reset source
   // ---------------------------------------------
   // called just after a clk edge; the pulse length is given in clk cycles
   task pulse_reset(input int n);
      reset_req <= 1'b1;
      repeat (n) @(posedge clk);
      reset_req <= 1'b0;
   endtask : pulse_reset
endmodule : hmawc_partner

// file: halt_mode_autowake_control_tb.sv
// self-checking bench for the halt and auto-wakeup controller
// assumes hmawc_top with a one-wait-state apb slave and the partner model beside it
`timescale 1ns/10ps

module halt_mode_autowake_control_tb;
   // ---------------------------------------------
   // signals
   // ---------------------------------------------
   logic clk = 1'b0;
   logic rst_n, psel, penable, pwrite, opv, irq_pend, timebase_irq_enable, overflow_irq_enable, sel_hi, sel_lo;
   logic wd_en, wd_opt, lt_irq, st_irq, hx_irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd, prdata;
   logic [7:0] opc;
   logic pready, pslverr, osc_on, tmr_en, per_en, stall, clr_mask, fetch_rv, svc_irq;
   logic wd_rst, aw_irq, rc_en, lt_cap, rc_clk, reset_req, seen0, seen1;
   int mismatches = 0;
   int checks = 0;
   int n;
   wire [3:0] ev = {fetch_rv, svc_irq, wd_rst, clr_mask};

   always #20 clk = ~clk;

   hmawc_top dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .OPCODE_VALID(opv), .OPCODE(opc), .CPU_RESET_REQ(reset_req), .IRQ_PENDING(irq_pend),
      .TIMEBASE_IRQ_ENABLE(timebase_irq_enable), .OVERFLOW_IRQ_ENABLE(overflow_irq_enable), .SECOND_TIMER_CLOCK_SEL_HI(sel_hi),
      .SECOND_TIMER_CLOCK_SEL_LO(sel_lo), .WATCHDOG_ENABLED(wd_en), .WATCHDOG_HALT_OPTION(wd_opt),
      .LITE_TIMER_IRQ(lt_irq), .SECOND_TIMER_IRQ(st_irq), .HALT_EXIT_IRQ(hx_irq),
      .AUTOWAKE_RC_CLK(rc_clk), .MAIN_OSC_ON(osc_on), .TIMER_CLK_EN(tmr_en), .PERIPH_CLK_EN(per_en),
      .CPU_STALL(stall), .CLEAR_IRQ_MASK(clr_mask), .FETCH_RESET_VECTOR(fetch_rv),
      .SERVICE_IRQ(svc_irq), .WATCHDOG_RESET(wd_rst), .AUTOWAKE_IRQ(aw_irq),
      .AUTOWAKE_RC_EN(rc_en), .LITE_TIMER_CAPTURE(lt_cap));

   hmawc_partner partner (.clk(clk), .rc_en(rc_en), .rc_clk(rc_clk), .reset_req(reset_req));

   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task finish_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   // outputs are read just after an edge, so they hold the values sampled at it
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wait_ev(input int i, input int lim);
      n = 0;
      while (ev[i] !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_ev

   task do_halt(input logic [7:0] op);
      @(posedge clk);
      opv <= 1'b1;
      opc <= op;
      @(posedge clk);
      opv <= 1'b0;
      @(posedge clk);
   endtask : do_halt

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task regs_and_measure;
      check({osc_on, tmr_en, per_en, stall}, 4'b1110);
      apb(0, 12'h000, 0);
      check(rd, 32'h0000_0000);
      apb(0, 12'h004, 0);
      check(rd, 32'h0000_00FF);
      apb(0, 12'h010, 0);
      check(err, 1);
      check(rd, 32'h0000_0000);
      apb(1, 12'h004, 32'h0000_0000);
      apb(0, 12'h004, 0);
      check(rd, 32'h0000_00FF);
      apb(1, 12'h004, 32'h0000_0001);
      apb(0, 12'h004, 0);
      check(rd, 32'h0000_0001);
      apb(1, 12'h000, 32'h0000_00FF);
      apb(0, 12'h000, 0);
      check(rd, 32'h0000_0003);
      seen0 = 1'b0;
      seen1 = 1'b0;
      repeat (60) begin
         @(posedge clk);
         seen0 |= (lt_cap === 1'b0);
         seen1 |= (lt_cap === 1'b1);
      end
      check({rc_en, seen0, seen1}, 3'b111);
      apb(1, 12'h000, 32'h0000_0000);
      apb(0, 12'h000, 0);
      check(rd, 32'h0000_0000);
      repeat (8) @(posedge clk);
      check(rc_en, 0);
   endtask : regs_and_measure

   task opcode_decode;
      do_halt(8'h8F);
      check({stall, clr_mask}, 2'b00);
      wd_opt <= 1'b1;
      do_halt(8'h8E);
      check({wd_rst, stall}, 2'b10);
      wd_opt <= 1'b0;
   endtask : opcode_decode

   // src: 0 lite timer, 1 second timer, 2 short reset, 3 long reset, 4 pending irq, 5 autowake
   task halt_case(input logic [3:0] cfg, input logic osc, input int src, input int evi,
                  input int lo, input int hi);
      {timebase_irq_enable, overflow_irq_enable, sel_hi, sel_lo} <= cfg;
      irq_pend <= (src == 4);
      do_halt(8'h8E);
      check({clr_mask, stall, wd_rst}, 3'b110);
      check({per_en, osc_on, tmr_en}, {1'b0, osc, osc});
      if (src == 5) check(rc_en, 1);
      case (src)
         0: begin
            hx_irq <= 1'b1;
            irq_pend <= 1'b1;
            apb(0, 12'h00C, 0);
            check(rd, 32'h0000_0001);
            apb(0, 12'h008, 0);
            check(rd, 32'h0000_0001);
            repeat (4) @(posedge clk);
            check(stall, 1);
            hx_irq <= 1'b0;
            irq_pend <= 1'b0;
            lt_irq <= 1'b1;
         end
         1: st_irq <= 1'b1;
         2: fork partner.pulse_reset(2); join_none
         3: fork partner.pulse_reset(1050); join_none
         default: ;
      endcase
      wait_ev(evi, hi + 10);
      check(32'(n >= lo && n <= hi), 1);
      check(stall, 0);
      lt_irq <= 1'b0;
      st_irq <= 1'b0;
      irq_pend <= 1'b0;
      wait fork;
      repeat (8) @(posedge clk);
   endtask : halt_case

   task autowake;
      apb(1, 12'h004, 32'h0000_0001);
      apb(1, 12'h000, 32'h0000_0001);
      halt_case(4'b0000, 0, 5, 2, 540, 650);
      check(aw_irq, 1);
      apb(0, 12'h000, 0);
      check(rd, 32'h0000_0005);
      apb(0, 12'h000, 0);
      check(aw_irq, 0);
      check(rd, 32'h0000_0001);
      apb(1, 12'h000, 32'h0000_0000);
   endtask : autowake

   // ---------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------
   initial begin
      {rst_n, psel, penable, pwrite, opv, irq_pend, timebase_irq_enable, overflow_irq_enable, sel_hi, sel_lo} = '0;
      {wd_opt, lt_irq, st_irq, hx_irq} = '0;
      wd_en = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      opc = 8'h00;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      regs_and_measure();
      opcode_decode();
      halt_case(4'b1000, 1, 0, 2, 0, 8);
      halt_case(4'b0101, 1, 1, 2, 0, 8);
      halt_case(4'b1000, 1, 2, 3, 256, 264);
      halt_case(4'b0111, 0, 3, 3, 256, 264);
      {wd_en, wd_opt} <= 2'b01;
      halt_case(4'b0000, 0, 4, 2, 256, 262);
      wd_en <= 1'b1;
      wd_opt <= 1'b0;
      autowake();
      finish_test();
   end

   initial begin
      #(40 * 20000);
      mismatches++;
      finish_test();
   end
endmodule : halt_mode_autowake_control_tb
